// *** io_config_registers.sv ***
`timescale 1ns/1ps
`include "io_config_params.svh"
// Contract
// - Bit 7 clear drives antenna differentially; set uses one output driver only.
// - Single-ended: select 0 picks first driver and input, 1 the second pair.
// - Hold-time field picks 380/160, 180/160, 180/70 or 100/70 ns per speed.
// - With crystal running, clock select gives hclk/8, /4, /2 (3.125, 6.25, 12.5 MHz at 40 ns) or off.
// - Disabled clock code holds the host clock pin permanently low.
// - Crystal stopped and output enabled: 32 kHz clock shown unless suppressed.
// - Tuning converters active only with tuning and oscillator enable both set.
// - Selected pull-down: pull data-out low while chip select low and undriven.
// - Deselected pull-down: pull data-out low while chip select is high.
// - Both pull-down settings act only in SPI mode, ignored in I2C mode.
// - Drive-level bit raises strength of data-out, host clock and interrupt pins.
// - Reference select 0 uses driver supply, 1 uses RF supply for regulator.
module io_config_registers (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Device state from neighbouring logic, same clock
   input  wire logic        osc_enable,
   input  wire logic        spi_mode,
   input  wire logic        hs_mode,
   input  wire logic        dout_driving,
   // Asynchronous pins
   input  wire logic        xtal_running,
   input  wire logic        slow_clock_in,
   input  wire logic        chip_select_n,
   // Pin and analog controls
   output logic             host_clk_out,
   output logic             dout_pulldown_en,
   output logic             first_antenna_output_en,
   output logic             second_antenna_output_en,
   output logic             second_receive_input_sel,
   output logic             tuning_dac_active,
   output logic             tuning_hold_fixed,
   output logic [3:0]       hold_time_cycles,
   output logic             io_drive_strong,
   output logic             mod_reg_ref_select,
   output logic             active_sink_en
);

   localparam logic [3:0] THD_380 = 4'(`NS_TO_CYCLES(`THD_380_NS));
   localparam logic [3:0] THD_180 = 4'(`NS_TO_CYCLES(`THD_180_NS));
   localparam logic [3:0] THD_160 = 4'(`NS_TO_CYCLES(`THD_160_NS));
   localparam logic [3:0] THD_100 = 4'(`NS_TO_CYCLES(`THD_100_NS));
   localparam logic [3:0] THD_70  = 4'(`NS_TO_CYCLES(`THD_70_NS));

   io_config_pkg::state_type state_q;
   io_config_pkg::state_type state_d;

   // Hold time for the current bus speed
   function automatic logic [3:0] hold_lookup(
      input logic [1:0] sel,
      input logic       fast
   );
      logic [3:0] t;
      t = THD_380;
      unique case (sel)
         2'h0: begin
            t = fast ? THD_160 : THD_380;
         end
         2'h1: begin
            t = fast ? THD_160 : THD_180;
         end
         2'h2: begin
            t = fast ? THD_70 : THD_180;
         end
         2'h3: begin
            t = fast ? THD_70 : THD_100;
         end
      endcase
      return t;
   endfunction

   // Register read mux
   function automatic logic [31:0] read_word(
      input io_config_pkg::state_type s,
      input logic [1:0]               idx,
      input logic                     mapped
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      if (mapped) begin
         unique case (idx)
            `IDX_IO_CONFIG_FIRST: begin
               w[7:0] = s.cfg_first;
            end
            `IDX_IO_CONFIG_SECOND: begin
               w[7:0] = s.cfg_second;
            end
            `IDX_IO_STATUS: begin
               w[`FS_XTAL_RUNNING]  = s.xtal_s2;
               w[`FS_TUNING_ARMED]  = s.tuning_armed;
               w[`FS_HOST_CLK_LEVEL] = s.host_clk;
               w[`FS_DOUT_PULLDOWN] = s.dout_pulldown;
            end
            default: begin
               w = 32'h0000_0000;
            end
         endcase
      end
      return w;
   endfunction

   logic       addr_phase;
   logic       addr_mapped;
   logic [1:0] addr_idx;
   logic [2:0] cnt_next;
   logic       sel_bit;
   logic       lf_allowed;

   always_comb begin
      state_d = state_q;

      // Bus address phase; only word registers in the low space answer
      addr_phase  = hsel & hready & htrans[1];
      addr_idx    = haddr[3:2];
      addr_mapped = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0)
                    && (addr_idx != 2'h3);

      // Data phase write from the previous address phase
      state_d.wr_pend = addr_phase & hwrite & addr_mapped;
      state_d.wr_idx  = addr_idx;
      if (state_q.wr_pend) begin
         if (state_q.wr_idx == `IDX_IO_CONFIG_FIRST) begin
            state_d.cfg_first = hwdata[7:0];
         end else if (state_q.wr_idx == `IDX_IO_CONFIG_SECOND) begin
            state_d.cfg_second = hwdata[7:0];
         end
      end

      // Read data prepared at the address phase so it leaves a flip-flop
      if (addr_phase & ~hwrite) begin
         state_d.hrdata = read_word(state_q, addr_idx, addr_mapped);
      end else begin
         state_d.hrdata = 32'h0000_0000;
      end
      state_d.hreadyout = 1'b1;

      // Two-stage synchronisers for pins
      state_d.lf_s1   = slow_clock_in;
      state_d.lf_s2   = state_q.lf_s1;
      state_d.xtal_s1 = xtal_running;
      state_d.xtal_s2 = state_q.xtal_s1;
      state_d.cs_s1   = chip_select_n;
      state_d.cs_s2   = state_q.cs_s1;

      // Sticky until reset: the fixed value needs a prior enable
      if (osc_enable) begin
         state_d.tuning_armed = 1'b1;
      end

      // Divider; select changes only where every divided clock restarts low
      cnt_next = state_q.div_cnt + 3'h1;
      state_d.div_cnt = cnt_next;
      if (cnt_next == 3'h0) begin
         state_d.clk_sel = io_config_pkg::host_clk_sel_type'(
            {state_q.cfg_first[`F1_HOST_CLK_SEL_HI],
             state_q.cfg_first[`F1_HOST_CLK_SEL_LO]});
      end
      unique case (state_d.clk_sel)
         io_config_pkg::host_clk_div8: begin
            sel_bit = cnt_next[2];
         end
         io_config_pkg::host_clk_div4: begin
            sel_bit = cnt_next[1];
         end
         io_config_pkg::host_clk_div2: begin
            sel_bit = cnt_next[0];
         end
         io_config_pkg::host_clk_off: begin
            sel_bit = 1'b0;
         end
      endcase

      // Stopped crystal falls back to the slow clock unless suppressed or the clock code is off
      lf_allowed = ~state_q.cfg_first[`F1_SLOW_CLOCK_SUPPRESS]
                   & (state_d.clk_sel != io_config_pkg::host_clk_off);
      if (state_q.xtal_s2) begin
         state_d.host_clk = sel_bit;
      end else begin
         state_d.host_clk = lf_allowed & state_q.lf_s2;
      end

      // Antenna driver and receive input choice
      if (state_q.cfg_first[`F1_SINGLE_ENDED]) begin
         state_d.first_driver_en  = ~state_q.cfg_first[`F1_DRIVER_PAIR_SELECT];
         state_d.second_driver_en = state_q.cfg_first[`F1_DRIVER_PAIR_SELECT];
         state_d.second_input_sel = state_q.cfg_first[`F1_DRIVER_PAIR_SELECT];
      end else begin
         state_d.first_driver_en  = 1'b1;
         state_d.second_driver_en = 1'b1;
         state_d.second_input_sel = 1'b0;
      end

      state_d.hold_cycles = hold_lookup(
         {state_q.cfg_first[`F1_HOLD_TIME_SEL_HI],
          state_q.cfg_first[`F1_HOLD_TIME_SEL_LO]}, hs_mode);

      // Tuning converters
      state_d.dac_active = state_q.cfg_second[`F2_TUNING_ENABLE] & osc_enable;
      state_d.dac_hold_fixed = state_q.cfg_second[`F2_TUNING_ENABLE] & ~osc_enable
                               & state_q.tuning_armed;

      // Data-out pull-downs, SPI only
      state_d.dout_pulldown = spi_mode & (
         (state_q.cfg_second[`F2_DOUT_PULLDOWN_SELECTED]
          & ~state_q.cs_s2 & ~dout_driving)
         | (state_q.cfg_second[`F2_DOUT_PULLDOWN_DESELECTED] & state_q.cs_s2));

      state_d.drive_strong = state_q.cfg_second[`F2_DRIVE_LEVEL];
      state_d.mod_ref_rf   = state_q.cfg_second[`F2_MOD_REG_REF_SELECT];
      // Left to software when to turn the sink on
      state_d.active_sink  = state_q.cfg_second[`F2_ACTIVE_SINK];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q                  <= '0;
         state_q.cfg_first        <= `RST_IO_CONFIG_FIRST;
         state_q.cfg_second       <= `RST_IO_CONFIG_SECOND;
         state_q.clk_sel          <= io_config_pkg::host_clk_div8;
         state_q.first_driver_en  <= 1'b1;
         state_q.second_driver_en <= 1'b1;
         state_q.hold_cycles      <= THD_380;
         state_q.hreadyout        <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   // Every output except hresp (tied low) straight from the state register
   assign hreadyout                = state_q.hreadyout;
   assign hrdata                   = state_q.hrdata;
   assign hresp                    = 1'b0;
   assign host_clk_out             = state_q.host_clk;
   assign dout_pulldown_en         = state_q.dout_pulldown;
   assign first_antenna_output_en  = state_q.first_driver_en;
   assign second_antenna_output_en = state_q.second_driver_en;
   assign second_receive_input_sel = state_q.second_input_sel;
   assign tuning_dac_active        = state_q.dac_active;
   assign tuning_hold_fixed        = state_q.dac_hold_fixed;
   assign hold_time_cycles         = state_q.hold_cycles;
   assign io_drive_strong          = state_q.drive_strong;
   assign mod_reg_ref_select       = state_q.mod_ref_rf;
   assign active_sink_en           = state_q.active_sink;

endmodule

// *** io_config_params.svh ***
`ifndef IO_CONFIG_PARAMS_SVH
`define IO_CONFIG_PARAMS_SVH

// Register indices and byte addresses (index times four)
`define IDX_IO_CONFIG_FIRST   2'h0
`define IDX_IO_CONFIG_SECOND  2'h1
`define IDX_IO_STATUS         2'h2
`define RST_IO_CONFIG_FIRST   8'h00
`define RST_IO_CONFIG_SECOND  8'h00

// First register fields
`define F1_SINGLE_ENDED       7
`define F1_DRIVER_PAIR_SELECT 6
`define F1_HOLD_TIME_SEL_HI   5
`define F1_HOLD_TIME_SEL_LO   4
`define F1_HOST_CLK_SEL_HI    2
`define F1_HOST_CLK_SEL_LO    1
`define F1_SLOW_CLOCK_SUPPRESS 0

// Second register fields
`define F2_TUNING_ENABLE      5
`define F2_DOUT_PULLDOWN_SELECTED   4
`define F2_DOUT_PULLDOWN_DESELECTED 3
`define F2_DRIVE_LEVEL        2
`define F2_MOD_REG_REF_SELECT 1
`define F2_ACTIVE_SINK        0

// Status register fields
`define FS_XTAL_RUNNING       0
`define FS_TUNING_ARMED       1
`define FS_HOST_CLK_LEVEL     2
`define FS_DOUT_PULLDOWN      3

// Timing
`define CLK_PERIOD_PS         40000
`define THD_380_NS            380
`define THD_180_NS            180
`define THD_160_NS            160
`define THD_100_NS            100
`define THD_70_NS             70
`define NS_TO_CYCLES(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// *** io_config_pkg.sv ***
package io_config_pkg;

   typedef enum logic [1:0] {
      host_clk_div8,
      host_clk_div4,
      host_clk_div2,
      host_clk_off
   } host_clk_sel_type;

   typedef struct packed {
      logic [7:0]       cfg_first;
      logic [7:0]       cfg_second;
      logic             wr_pend;
      logic [1:0]       wr_idx;
      logic             tuning_armed;
      logic [2:0]       div_cnt;
      host_clk_sel_type clk_sel;
      logic             lf_s1;
      logic             lf_s2;
      logic             xtal_s1;
      logic             xtal_s2;
      logic             cs_s1;
      logic             cs_s2;
      logic             host_clk;
      logic             dout_pulldown;
      logic             first_driver_en;
      logic             second_driver_en;
      logic             second_input_sel;
      logic             dac_active;
      logic             dac_hold_fixed;
      logic [3:0]       hold_cycles;
      logic             drive_strong;
      logic             mod_ref_rf;
      logic             active_sink;
      logic [31:0]      hrdata;
      logic             hreadyout;
   } state_type;

endpackage

// *** io_config_registers_monitor.sv ***
`timescale 1ns/1ps
module io_config_registers_monitor (
   // Clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   // Device state and pins
   input wire logic        osc_enable,
   input wire logic        spi_mode,
   input wire logic        hs_mode,
   input wire logic        host_clk_out,
   input wire logic        dout_pulldown_en,
   input wire logic        first_antenna_output_en,
   input wire logic        second_antenna_output_en,
   input wire logic        second_receive_input_sel,
   input wire logic        tuning_dac_active,
   input wire logic        tuning_hold_fixed,
   input wire logic [3:0]  hold_time_cycles
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_ready_zero_wait: assert property (hreadyout) else $error("wait state inserted");
   a_rdata_phase: assert property (hrdata != 32'h0 |->
      $past(hsel && hready && htrans[1] && !hwrite)) else $error("read data outside read");
   a_pair_excl: assert property (second_receive_input_sel |->
      second_antenna_output_en && !first_antenna_output_en) else $error("pair mixed");
   a_drive_some: assert property (first_antenna_output_en || second_antenna_output_en)
      else $error("no antenna driver");
   a_tune_active: assert property (tuning_dac_active |->
      $past(osc_enable) && !tuning_hold_fixed) else $error("tuning active without osc");
   a_tune_fixed: assert property (tuning_hold_fixed |-> !$past(osc_enable))
      else $error("tuning fixed with osc");
   a_pd_i2c: assert property (!$past(spi_mode) |-> !dout_pulldown_en)
      else $error("pull-down in i2c mode");
   a_hold_fast: assert property ($past(hresetn) && $past(hs_mode) |->
      hold_time_cycles inside {4'h4, 4'h2}) else $error("fast hold time wrong");
   a_hold_slow: assert property ($past(hresetn) && !$past(hs_mode) |->
      hold_time_cycles inside {4'ha, 4'h5, 4'h3}) else $error("normal hold time wrong");

   c_fixed: cover property (tuning_hold_fixed);
   c_pulldown: cover property (dout_pulldown_en);
   c_host_clk: cover property ($rose(host_clk_out));
endmodule

// *** spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
   // Clock
   input  wire logic hclk,
   // Control and observation
   input  wire logic cs_assert,
   input  wire logic clr,
   input  wire logic host_clk,
   output logic      chip_select_n,
   output logic [7:0] rises
);
   logic prev_q;
   // Rising edges of the device clock pin, counted per sampled hclk
   always_ff @(posedge hclk) begin
      chip_select_n <= ~cs_assert;
      prev_q <= host_clk;
      rises <= clr ? 8'h00 : rises + {7'h0, host_clk & ~prev_q};
   end
endmodule

// *** io_config_registers_test.sv ***
`timescale 1ns/1ps
bind io_config_registers io_config_registers_monitor i_io_config_registers_monitor (.hclk,
   .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hrdata, .hresp, .osc_enable, .spi_mode, .hs_mode,
   .host_clk_out, .dout_pulldown_en, .first_antenna_output_en, .second_antenna_output_en,
   .second_receive_input_sel, .tuning_dac_active, .tuning_hold_fixed, .hold_time_cycles);
module io_config_registers_test;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, arm, clr, cs_assert;
   logic        osc_enable, spi_mode, hs_mode, dout_driving, xtal_running, slow_clock_in;
   logic        chip_select_n, host_clk_out, dout_pulldown_en, first_antenna_output_en;
   logic        second_antenna_output_en, second_receive_input_sel, tuning_dac_active;
   logic        tuning_hold_fixed, io_drive_strong, mod_reg_ref_select, active_sink_en;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  hold_time_cycles;
   logic [7:0]  c1, c2, rises;
   logic [31:0] haddr, hwdata, hrdata, rd, r;
   int          n_errors, compares;

   io_config_registers i_io_config_registers (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .osc_enable, .spi_mode,
      .hs_mode, .dout_driving, .xtal_running, .slow_clock_in, .chip_select_n, .host_clk_out,
      .dout_pulldown_en, .first_antenna_output_en, .second_antenna_output_en,
      .second_receive_input_sel, .tuning_dac_active, .tuning_hold_fixed, .hold_time_cycles,
      .io_drive_strong, .mod_reg_ref_select, .active_sink_en);
   spi_host_model i_spi_host_model (.hclk, .cs_assert, .clr, .host_clk(host_clk_out),
      .chip_select_n, .rises);

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [31:0] exp_pins(input logic [7:0] a, b,
                                            input logic spi, hs, osc, drv, csn, armed);
      logic [3:0] h;
      case (a[5:4])
         2'h0: h = hs ? 4'h4 : 4'ha;
         2'h1: h = hs ? 4'h4 : 4'h5;
         2'h2: h = hs ? 4'h2 : 4'h5;
         default: h = hs ? 4'h2 : 4'h3;
      endcase
      return {19'h0, h, !a[7] | !a[6], !a[7] | a[6], a[7] & a[6], b[5] & osc,
              b[5] & !osc & armed, spi & ((b[4] & !csn & !drv) | (b[3] & csn)), b[2:0]};
   endfunction

   task automatic ahb(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input logic [31:0] g, e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Settle past the divider wrap, then count over a whole number of periods
   task automatic meas;
      repeat (16) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (64) @(posedge hclk);
      @(posedge hclk);
   endtask

   task automatic close_out;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   initial begin
      slow_clock_in = 1'b0;
      forever begin
         repeat (20) @(posedge hclk);
         slow_clock_in <= ~slow_clock_in;
      end
   end

   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, clr, cs_assert, arm} = '0;
      {osc_enable, spi_mode, hs_mode, dout_driving, xtal_running} = '0;
      hsize = 3'h2;
      r = 32'h02647942;
      n_errors = 0;
      compares = 0;
      fork
         begin
            repeat (6) @(posedge hclk);
            hresetn <= 1'b1;
            ahb(1'b0, 32'h0, 32'h0);
            chk(rd, 32'h0);
            ahb(1'b0, 32'h4, 32'h0);
            chk(rd, 32'h0);
            for (int i = 0; i < 14; i++) begin
               r = lfsr(r);
               c1 = (i < 3) ? 8'hc4 : r[15:8] & 8'hf7;
               c2 = (i < 3) ? 8'h3f : r[23:16] & 8'h3f;
               // First passes set the oscillator once, then clear it with tuning kept on
               osc_enable <= (i < 3) ? (i == 1) : r[2];
               spi_mode <= r[0];
               hs_mode <= r[1];
               dout_driving <= r[3];
               cs_assert <= r[4];
               ahb(1'b1, 32'h0, {24'h0, c1});
               ahb(1'b1, 32'h4, {24'h0, c2});
               ahb(1'b0, 32'h0, 32'h0);
               chk(rd, {24'h0, c1});
               ahb(1'b0, 32'h4, 32'h0);
               chk(rd, {24'h0, c2});
               chk({19'h0, hold_time_cycles, first_antenna_output_en,
                    second_antenna_output_en, second_receive_input_sel, tuning_dac_active,
                    tuning_hold_fixed, dout_pulldown_en, io_drive_strong, mod_reg_ref_select,
                    active_sink_en}, exp_pins(c1, c2, spi_mode, hs_mode, osc_enable,
                    dout_driving, chip_select_n,
                    arm));
               arm = arm | osc_enable;
            end
            ahb(1'b1, 32'hc, 32'hff);
            ahb(1'b0, 32'h0, 32'h0);
            chk(rd, {24'h0, c1});
            ahb(1'b0, 32'hc, 32'h0);
            chk(rd, 32'h0);
            xtal_running <= 1'b1;
            for (int k = 0; k < 4; k++) begin
               ahb(1'b1, 32'h0, 32'(k << 1));
               meas();
               chk({24'h0, rises}, (k == 3) ? 32'h0 : 32'h8 << k);
            end
            xtal_running <= 1'b0;
            ahb(1'b1, 32'h0, 32'h0);
            meas();
            chk({31'h0, rises != 8'h0}, 32'h1);
            ahb(1'b1, 32'h0, 32'h1);
            meas();
            chk({24'h0, rises}, 32'h0);
            ahb(1'b1, 32'h0, 32'h6);
            meas();
            chk({24'h0, rises}, 32'h0);
            // Crystal stopped, clock pin low, oscillator seen once; pull-down left random
            ahb(1'b0, 32'h8, 32'h0);
            chk(rd & 32'hffff_fff7, 32'h2);
         end
         begin
            // Ceiling far above the roughly 790 cycles the scenarios need
            for (int t = 0; t < 8000; t++)
               @(posedge hclk);
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
         end
      join_any
      close_out();
   end
endmodule
